// File: common/eoc_defines.svh
// Constants for the encoder-over-CAN block
`ifndef EOC_DEFINES_SVH
`define EOC_DEFINES_SVH
`define EOC_OFF_CTRL   8'h00
`define EOC_OFF_STAT   8'h04
`define EOC_OFF_ARATE  8'h08
`define EOC_OFF_ANODE  8'h0C
`define EOC_OFF_BRATE  8'h10
`define EOC_OFF_BNODE  8'h14
`define EOC_OFF_APTR   8'h18
`define EOC_OFF_BPTR   8'h1C
`define EOC_OFF_INADR  8'h20
`define EOC_OFF_DEN    8'h24
`define EOC_OFF_NUM    8'h28
`define EOC_OFF_COUNT  8'h2C
`define EOC_B_AIN      0
`define EOC_B_AOUT     1
`define EOC_B_AVIRT    2
`define EOC_B_BEN      3
`define EOC_B_BVIRT    4
`define EOC_F_BEXP     9:5
`define EOC_B_AINIT    10
`define EOC_B_BINIT    11
`define EOC_B_WDOG     0
`define EOC_F5         4:0
`define EOC_F8         7:0
`define EOC_F9         8:0
`define EOC_RATE_RST   5'h01
`define EOC_NODE_RST   5'h01
`define EOC_RATIO_RST  8'h01
`define EOC_EXCL_OPM   8'h8C
`define EOC_CLK_NS     5
`define EOC_A_PER_US   1024
`define EOC_B_PER_US   5000
`endif

// File: common/eoc_pkg.sv
// Types for the encoder-over-CAN block
`default_nettype none
package eoc_pkg;
    typedef enum logic [3:0] {
        R_CTRL, R_STAT, R_ARATE, R_ANODE, R_BRATE, R_BNODE,
        R_APTR, R_BPTR, R_INADR, R_DEN, R_NUM, R_COUNT, R_NONE
    } eoc_reg_t;

    typedef struct packed {
        logic [4:0]  a_rate;
        logic [4:0]  a_node;
        logic [4:0]  b_rate;
        logic [4:0]  b_node;
        logic [7:0]  a_ptr;
        logic [8:0]  b_ptr;
        logic [7:0]  in_addr;
        logic [7:0]  den;
        logic [7:0]  num;
        logic        a_in_nv;
        logic        a_out_nv;
        logic        a_virt;
        logic        b_en;
        logic        b_virt;
        logic [4:0]  b_exp;
        logic        booted;
        logic        a_in_act;
        logic        a_out_act;
        logic        wdog;
        logic        a_init;
        logic        b_init;
        logic [19:0] a_tmr;
        logic [19:0] b_tmr;
        logic        a_tx_v;
        logic        b_tx_v;
        logic [31:0] a_tx_d;
        logic [31:0] b_tx_d;
        logic [31:0] cnt;
        logic [31:0] last;
        logic        have_ref;
        logic [31:0] rdat;
    } eoc_state_t;
endpackage
`default_nettype wire

// File: rtl/eoc_top.sv
// Encoder-over-CAN position transmitter and receiver
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "eoc_defines.svh"
module eoc_top #(
    parameter int PER_A_CYC = `EOC_A_PER_US * 1000 / `EOC_CLK_NS,
    parameter int PER_B_CYC = `EOC_B_PER_US * 1000 / `EOC_CLK_NS
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        saved_a_in_en,
    input  wire logic        saved_a_out_en,
    output logic             nv_a_in_en,
    output logic             nv_a_out_en,
    input  wire logic [7:0]  opmode,
    input  wire logic [31:0] motor_pos,
    input  wire logic [31:0] a_param_val,
    input  wire logic [31:0] b_param_val,
    output logic      [7:0]  a_src_ptr,
    output logic      [8:0]  b_src_ptr,
    output logic             a_tx_valid,
    output logic      [4:0]  a_tx_addr,
    output logic      [31:0] a_tx_data,
    output logic      [4:0]  a_tx_rate,
    output logic             a_line_init,
    output logic             b_tx_valid,
    output logic      [4:0]  b_tx_addr,
    output logic      [31:0] b_tx_data,
    output logic      [4:0]  b_tx_rate,
    output logic             b_line_init,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_addr,
    input  wire logic [31:0] rx_data
);
    localparam logic [19:0] A_RLD = 20'(PER_A_CYC - 1);
    localparam logic [19:0] B_RLD = 20'(PER_B_CYC - 1);

    eoc_pkg::eoc_state_t st_q;
    eoc_pkg::eoc_state_t st_d;
    eoc_pkg::eoc_reg_t   rsel;
    logic                excl;
    logic                a_run;
    logic                b_run;
    logic                loop;
    logic                rx_hit;
    logic [31:0]         word;
    logic [31:0]         inc;
    logic signed [40:0]  prod;
    logic signed [40:0]  quo;

    function automatic eoc_pkg::eoc_reg_t reg_dec(
        input logic [7:0] a
    );
        eoc_pkg::eoc_reg_t r;
        r = eoc_pkg::R_NONE;
        unique case (a)
            `EOC_OFF_CTRL:  r = eoc_pkg::R_CTRL;
            `EOC_OFF_STAT:  r = eoc_pkg::R_STAT;
            `EOC_OFF_ARATE: r = eoc_pkg::R_ARATE;
            `EOC_OFF_ANODE: r = eoc_pkg::R_ANODE;
            `EOC_OFF_BRATE: r = eoc_pkg::R_BRATE;
            `EOC_OFF_BNODE: r = eoc_pkg::R_BNODE;
            `EOC_OFF_APTR:  r = eoc_pkg::R_APTR;
            `EOC_OFF_BPTR:  r = eoc_pkg::R_BPTR;
            `EOC_OFF_INADR: r = eoc_pkg::R_INADR;
            `EOC_OFF_DEN:   r = eoc_pkg::R_DEN;
            `EOC_OFF_NUM:   r = eoc_pkg::R_NUM;
            `EOC_OFF_COUNT: r = eoc_pkg::R_COUNT;
            default:        r = eoc_pkg::R_NONE;
        endcase
        return r;
    endfunction

    always_comb
    begin
        st_d = st_q;
        rsel = reg_dec(reg_addr);
        excl = (opmode == `EOC_EXCL_OPM);
        a_run = st_q.a_out_act && !excl;
        b_run = st_q.b_en && !excl;
        st_d.a_tx_v = 1'b0;
        st_d.b_tx_v = 1'b0;
        st_d.a_init = 1'b0;
        st_d.b_init = 1'b0;
        st_d.rdat = '0;

        // Saved enables become live only once per reset
        if (!st_q.booted)
        begin
            st_d.booted = 1'b1;
            st_d.a_in_act = saved_a_in_en;
            st_d.a_out_act = saved_a_out_en;
        end

        if (!a_run)
        begin
            st_d.a_tmr = A_RLD;
        end
        else if (st_q.a_tmr == '0)
        begin
            st_d.a_tmr = A_RLD;
            st_d.a_tx_v = 1'b1;
            st_d.a_tx_d = st_q.a_virt ? a_param_val : motor_pos;
        end
        else
        begin
            st_d.a_tmr = st_q.a_tmr - 20'h00001;
        end

        if (!b_run)
        begin
            st_d.b_tmr = B_RLD;
        end
        else if (st_q.b_tmr == '0)
        begin
            st_d.b_tmr = B_RLD;
            st_d.b_tx_v = 1'b1;
            st_d.b_tx_d = st_q.b_virt ? (b_param_val << st_q.b_exp)
                                      : motor_pos;
        end
        else
        begin
            st_d.b_tmr = st_q.b_tmr - 20'h00001;
        end

        if (reg_wr)
        begin
            unique case (rsel)
                eoc_pkg::R_CTRL:
                begin
                    st_d.a_in_nv = reg_wdata[`EOC_B_AIN];
                    st_d.a_out_nv = reg_wdata[`EOC_B_AOUT];
                    st_d.a_virt = reg_wdata[`EOC_B_AVIRT];
                    st_d.b_en = reg_wdata[`EOC_B_BEN];
                    st_d.b_virt = reg_wdata[`EOC_B_BVIRT];
                    st_d.b_exp = reg_wdata[`EOC_F_BEXP];
                    st_d.a_init = reg_wdata[`EOC_B_AINIT];
                    st_d.b_init = reg_wdata[`EOC_B_BINIT];
                end
                eoc_pkg::R_STAT:
                begin
                    if (reg_wdata[`EOC_B_WDOG])
                    begin
                        st_d.wdog = 1'b0;
                    end
                end
                eoc_pkg::R_ARATE: st_d.a_rate = reg_wdata[`EOC_F5];
                eoc_pkg::R_ANODE: st_d.a_node = reg_wdata[`EOC_F5];
                eoc_pkg::R_BRATE: st_d.b_rate = reg_wdata[`EOC_F5];
                eoc_pkg::R_BNODE: st_d.b_node = reg_wdata[`EOC_F5];
                eoc_pkg::R_APTR:  st_d.a_ptr = reg_wdata[`EOC_F8];
                eoc_pkg::R_BPTR:  st_d.b_ptr = reg_wdata[`EOC_F9];
                eoc_pkg::R_INADR: st_d.in_addr = reg_wdata[`EOC_F8];
                eoc_pkg::R_DEN:   st_d.den = reg_wdata[`EOC_F8];
                eoc_pkg::R_NUM:   st_d.num = reg_wdata[`EOC_F8];
                default:
                begin
                end
            endcase
        end

        // Own frame counts as received when addresses agree
        loop = st_q.a_tx_v && ({3'h0, st_q.a_node} == st_q.in_addr);
        rx_hit = st_q.a_in_act && !excl
                 && (loop || (rx_valid && rx_addr == st_q.in_addr));
        word = loop ? st_q.a_tx_d : rx_data;
        inc = word - st_q.last;
        prod = $signed(inc) * $signed({1'b0, st_q.num});
        quo = (st_q.den == '0) ? '0 : prod / $signed({1'b0, st_q.den});
        // Arrival comes after the clear so a same-cycle event wins
        if (rx_hit)
        begin
            st_d.wdog = 1'b1;
            st_d.last = word;
            st_d.have_ref = 1'b1;
            if (st_q.have_ref)
            begin
                st_d.cnt = st_q.cnt + quo[31:0];
            end
        end

        if (reg_rd)
        begin
            unique case (rsel)
                eoc_pkg::R_CTRL:
                    st_d.rdat = {20'h00000, 2'b00, st_q.b_exp, st_q.b_virt,
                                 st_q.b_en, st_q.a_virt, st_q.a_out_nv,
                                 st_q.a_in_nv};
                eoc_pkg::R_STAT:
                    st_d.rdat = {28'h0000000, excl, st_q.a_out_act,
                                 st_q.a_in_act, st_q.wdog};
                eoc_pkg::R_ARATE: st_d.rdat = {27'h0000000, st_q.a_rate};
                eoc_pkg::R_ANODE: st_d.rdat = {27'h0000000, st_q.a_node};
                eoc_pkg::R_BRATE: st_d.rdat = {27'h0000000, st_q.b_rate};
                eoc_pkg::R_BNODE: st_d.rdat = {27'h0000000, st_q.b_node};
                eoc_pkg::R_APTR:  st_d.rdat = {24'h000000, st_q.a_ptr};
                eoc_pkg::R_BPTR:  st_d.rdat = {23'h000000, st_q.b_ptr};
                eoc_pkg::R_INADR: st_d.rdat = {24'h000000, st_q.in_addr};
                eoc_pkg::R_DEN:   st_d.rdat = {24'h000000, st_q.den};
                eoc_pkg::R_NUM:   st_d.rdat = {24'h000000, st_q.num};
                eoc_pkg::R_COUNT: st_d.rdat = st_q.cnt;
                default:          st_d.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '0;
            st_q.a_rate <= `EOC_RATE_RST;
            st_q.b_rate <= `EOC_RATE_RST;
            st_q.a_node <= `EOC_NODE_RST;
            st_q.b_node <= `EOC_NODE_RST;
            st_q.den <= `EOC_RATIO_RST;
            st_q.num <= `EOC_RATIO_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdat;
    assign nv_a_in_en = st_q.a_in_nv;
    assign nv_a_out_en = st_q.a_out_nv;
    assign a_src_ptr = st_q.a_ptr;
    assign b_src_ptr = st_q.b_ptr;
    assign a_tx_valid = st_q.a_tx_v;
    assign a_tx_addr = st_q.a_node;
    assign a_tx_data = st_q.a_tx_d;
    assign a_tx_rate = st_q.a_rate;
    assign a_line_init = st_q.a_init;
    assign b_tx_valid = st_q.b_tx_v;
    assign b_tx_addr = st_q.b_node;
    assign b_tx_data = st_q.b_tx_d;
    assign b_tx_rate = st_q.b_rate;
    assign b_line_init = st_q.b_init;

    a_a_fire_time: assert property (
        @(posedge ref_clk) disable iff (reset)
        (a_run && st_q.a_tmr == '0) ##1 a_run |-> a_tx_valid
            ##1 (!a_tx_valid && st_q.a_tmr == A_RLD - 20'h00001)
    ) else $error("channel A send not on period");

    a_b_fire_time: assert property (
        @(posedge ref_clk) disable iff (reset)
        (b_run && st_q.b_tmr == '0) ##1 b_run |-> b_tx_valid
            ##1 (!b_tx_valid && st_q.b_tmr == B_RLD - 20'h00001)
    ) else $error("channel B send not on period");

    a_b_gated_off: assert property (
        @(posedge ref_clk) disable iff (reset)
        !st_q.b_en |=> !b_tx_valid
    ) else $error("channel B sent while disabled");

    a_excl_mode: assert property (
        @(posedge ref_clk) disable iff (reset)
        (opmode == `EOC_EXCL_OPM) |=> (!a_tx_valid && !b_tx_valid)
    ) else $error("send during excluded mode");

    a_a_src_motor: assert property (
        @(posedge ref_clk) disable iff (reset)
        (a_run && st_q.a_tmr == '0 && !st_q.a_virt)
            |=> a_tx_data == $past(motor_pos)
    ) else $error("channel A source not motor position");

    a_boot_latch: assert property (
        @(posedge ref_clk) disable iff (reset)
        st_q.booted |=> ($stable(st_q.a_in_act)
                         && $stable(st_q.a_out_act))
    ) else $error("enable changed after power-up");

    a_wdog_arrive: assert property (
        @(posedge ref_clk) disable iff (reset)
        rx_hit |=> st_q.wdog
    ) else $error("watchdog not set on arrival");

    a_addr_filter: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!loop && (!rx_valid || rx_addr != st_q.in_addr))
            |=> $stable(st_q.cnt) && $stable(st_q.last)
    ) else $error("count moved without matching message");

    a_loop_back: assert property (
        @(posedge ref_clk) disable iff (reset)
        (a_tx_valid && st_q.a_in_act && !excl
         && {3'h0, a_tx_addr} == st_q.in_addr)
            |=> st_q.last == $past(a_tx_data)
    ) else $error("own frame not taken as input");

    a_line_pulse: assert property (
        @(posedge ref_clk) disable iff (reset)
        (reg_wr && reg_addr == `EOC_OFF_CTRL && reg_wdata[`EOC_B_AINIT])
            |=> a_line_init ##1 !a_line_init
    ) else $error("line init pulse missing");

    a_rd_next: assert property (
        @(posedge ref_clk) disable iff (reset)
        (reg_rd && reg_addr == `EOC_OFF_COUNT)
            |=> reg_rdata == $past(st_q.cnt)
    ) else $error("count read mismatch");
endmodule
`default_nettype wire

// File: dv/eoc_peer.sv
// Far-side drive model: sends encoder frames and listens to channel A
`timescale 1ns/1ps
`default_nettype none
module eoc_peer (
    input  wire logic        ref_clk,
    input  wire logic        a_tx_valid,
    output logic             rx_valid,
    output logic      [7:0]  rx_addr,
    output logic      [31:0] rx_data,
    output int               heard
);
    initial
    begin
        rx_valid = 1'b0;
        rx_addr  = 8'hFF;
        rx_data  = 32'hFFFFFFFF;
        heard    = 0;
    end
    // Only the channel A stream is counted as it passes; channel B frames are not watched
    always @(posedge ref_clk)
        if (a_tx_valid === 1'b1)
            heard <= heard + 1;
    // Released lines show the inverse of the last frame
    task automatic send(input logic [7:0] adr, input logic [31:0] pos);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_addr  <= adr;
        rx_data  <= pos;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_addr  <= ~adr;
        rx_data  <= ~pos;
    endtask
endmodule
`default_nettype wire

// File: dv/eoc_top_test.sv
// Register-level testbench of the encoder-over-CAN block
`timescale 1ns/1ps
`default_nettype none
module eoc_top_test;
    logic        ref_clk, reset, reg_wr, reg_rd;
    logic [7:0]  reg_addr, opmode, a_src_ptr, rx_addr;
    logic [31:0] reg_wdata, reg_rdata, motor_pos, a_param_val, b_param_val;
    logic [31:0] a_tx_data, b_tx_data, rx_data;
    logic [8:0]  b_src_ptr;
    logic [4:0]  a_tx_addr, a_tx_rate, b_tx_addr, b_tx_rate;
    logic        nv_a_in_en, nv_a_out_en, a_tx_valid, b_tx_valid;
    logic        a_line_init, b_line_init, rx_valid;
    int          failures, tests_run, cyc, heard;
    int          a_n, b_n, a_last, b_last, a_gap, b_gap, ai_n, bi_n;
    int          a_tot;

    eoc_top #(.PER_A_CYC(20), .PER_B_CYC(30)) eoc_top_inst (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .saved_a_in_en(1'b1),
        .saved_a_out_en(1'b1), .nv_a_in_en(nv_a_in_en),
        .nv_a_out_en(nv_a_out_en), .opmode(opmode),
        .motor_pos(motor_pos), .a_param_val(a_param_val),
        .b_param_val(b_param_val), .a_src_ptr(a_src_ptr),
        .b_src_ptr(b_src_ptr), .a_tx_valid(a_tx_valid),
        .a_tx_addr(a_tx_addr), .a_tx_data(a_tx_data),
        .a_tx_rate(a_tx_rate), .a_line_init(a_line_init),
        .b_tx_valid(b_tx_valid), .b_tx_addr(b_tx_addr),
        .b_tx_data(b_tx_data), .b_tx_rate(b_tx_rate),
        .b_line_init(b_line_init), .rx_valid(rx_valid),
        .rx_addr(rx_addr), .rx_data(rx_data));

    eoc_peer eoc_peer_inst (.ref_clk(ref_clk), .a_tx_valid(a_tx_valid),
        .rx_valid(rx_valid), .rx_addr(rx_addr), .rx_data(rx_data),
        .heard(heard));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Frame spacing and pulse counts seen at the outputs
    always @(posedge ref_clk)
    begin
        cyc++;
        if (a_tx_valid === 1'b1)
        begin
            a_gap = cyc - a_last;
            a_last = cyc;
            a_n++;
            a_tot++;
        end
        if (b_tx_valid === 1'b1)
        begin
            b_gap = cyc - b_last;
            b_last = cyc;
            b_n++;
        end
        if (a_line_init === 1'b1)
            ai_n++;
        if (b_line_init === 1'b1)
            bi_n++;
        if (cyc == 3000)
        begin
            failures++;
            give_verdict();
        end
    end

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] adr, logic [31:0] dat);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= adr;
        reg_wdata <= dat;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(logic [7:0] adr, logic [31:0] exp, string what);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= adr;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    task automatic gap(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {cyc, failures, tests_run, a_n, b_n, ai_n, bi_n} = '0;
        {a_last, b_last, a_gap, b_gap, a_tot} = '0;
        opmode = 8'h00;
        motor_pos = 32'h000003E8;
        a_param_val = 32'hCAFE0001;
        b_param_val = 32'h00000011;
        reset = 1'b1;
        gap(6);
        reset <= 1'b0;
        rd(8'h08, 32'h1, "a rate reset");
        rd(8'h10, 32'h1, "b rate reset");
        rd(8'h0C, 32'h1, "a node reset");
        rd(8'h14, 32'h1, "b node reset");
        rd(8'h24, 32'h1, "den reset");
        rd(8'h28, 32'h1, "num reset");
        rd(8'h30, 32'h0, "unmapped");
        chk("b idle", 32'h0, b_n);
        gap(45);
        chk("a period", 32'd20, a_gap);
        chk("a motor", 32'h3E8, a_tx_data);
        chk("a addr", 32'h1, a_tx_addr);
        $display("test reset and channel A done");
        wr(8'h00, 32'h4);
        wr(8'h18, 32'hFF);
        wr(8'h08, 32'h1F);
        chk("nv in", 32'h0, nv_a_in_en);
        chk("nv out", 32'h0, nv_a_out_en);
        rd(8'h04, 32'h6, "still active");
        gap(25);
        chk("a virtual", 32'hCAFE0001, a_tx_data);
        chk("a ptr", 32'hFF, a_src_ptr);
        chk("a rate", 32'h1F, a_tx_rate);
        wr(8'h00, 32'h5C);
        wr(8'h1C, 32'h181);
        wr(8'h14, 32'h1F);
        gap(65);
        chk("b period", 32'd30, b_gap);
        chk("b scaled", 32'h44, b_tx_data);
        chk("b ptr", 32'h181, b_src_ptr);
        chk("b addr", 32'h1F, b_tx_addr);
        wr(8'h00, 32'h45C);
        wr(8'h00, 32'h85C);
        gap(2);
        chk("a init", 32'h1, ai_n);
        chk("b init", 32'h1, bi_n);
        $display("test virtual and channel B done");
        wr(8'h20, 32'h40);
        wr(8'h24, 32'h2);
        wr(8'h28, 32'h3);
        eoc_peer_inst.send(8'h41, 32'h3E8);
        rd(8'h04, 32'h6, "foreign frame");
        eoc_peer_inst.send(8'h40, 32'h3E8);
        rd(8'h04, 32'h7, "watchdog");
        eoc_peer_inst.send(8'h40, 32'h44C);
        rd(8'h2C, 32'h96, "count up");
        eoc_peer_inst.send(8'h40, 32'h3E8);
        wr(8'h2C, 32'h5);
        rd(8'h2C, 32'h0, "count down");
        wr(8'h04, 32'h1);
        rd(8'h04, 32'h6, "watchdog clear");
        $display("test receive done");
        motor_pos <= 32'h0000044C;
        wr(8'h00, 32'h18);
        wr(8'h20, 32'h1);
        gap(25);
        rd(8'h04, 32'h7, "loop watchdog");
        rd(8'h2C, 32'h96, "loop count");
        opmode <= 8'h8C;
        wr(8'h04, 32'h1);
        a_n = 0;
        gap(45);
        chk("mode stop", 32'h0, a_n);
        rd(8'h04, 32'hE, "mode flag");
        chk("peer frames", a_tot, heard);
        $display("test loopback and excluded mode done");
        give_verdict();
    end
endmodule
`default_nettype wire
